// file: core/ied_execute.sv
// Integer execute datapath: logic, arithmetic, moves, compares, ld/st
// Assumes decode raises i_valid for one cycle per op, then waits for o_ready; the bus
// answers each request with one i_bus_ack pulse
`timescale 1ns/1ps
`default_nettype none

module ied_execute
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic [5:0] i_op,
  input wire logic i_io,
  input wire logic [31:0] i_rs1,
  input wire logic [31:0] i_rs2,
  input wire logic [15:0] i_imm,
  input wire logic [4:0] i_rd,
  input wire logic i_bus_ack,
  input wire logic [31:0] i_bus_rdata,
  output logic o_ready,
  output logic o_wb_en,
  output logic [4:0] o_wb_rd,
  output logic [31:0] o_wb_data,
  output logic o_bus_req,
  output logic o_bus_we,
  output logic o_bus_uncached,
  output logic [31:0] o_bus_addr,
  output logic [3:0] o_bus_be,
  output logic [31:0] o_bus_wdata
);

  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_DIV} ied_state_t;

  typedef struct packed {
    ied_state_t state;
    logic ready;
    logic wb_en;
    logic [4:0] wb_rd;
    logic [31:0] wb_data;
    logic req;
    logic we;
    logic unc;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    ied_pkg::ied_op_t op;
    logic [1:0] lane;
  } ied_exe_st_t;

  ied_exe_st_t st_reg;
  ied_exe_st_t st_next;

  logic div_start;
  logic div_busy;
  logic div_done;
  logic [31:0] div_quot;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction : sext16

  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction : zext16

  function automatic logic is_load(input ied_pkg::ied_op_t o);
    is_load = (o == ied_pkg::OP_LDW) || (o == ied_pkg::OP_LDB) ||
              (o == ied_pkg::OP_LDBU) || (o == ied_pkg::OP_LDH) ||
              (o == ied_pkg::OP_LDHU);
  endfunction : is_load

  function automatic logic is_store(input ied_pkg::ied_op_t o);
    is_store = (o == ied_pkg::OP_STW) || (o == ied_pkg::OP_STB) ||
               (o == ied_pkg::OP_STH);
  endfunction : is_store

  function automatic logic [1:0] mem_size(input ied_pkg::ied_op_t o);
    case (o)
      ied_pkg::OP_LDB, ied_pkg::OP_LDBU, ied_pkg::OP_STB:
        mem_size = ied_pkg::SZ_BYTE;
      ied_pkg::OP_LDH, ied_pkg::OP_LDHU, ied_pkg::OP_STH:
        mem_size = ied_pkg::SZ_HALF;
      default:
        mem_size = ied_pkg::SZ_WORD;
    endcase
  endfunction : mem_size

  // ---------------------------------------------------------------
  // Operand shaping and combinational results
  // ---------------------------------------------------------------
  ied_pkg::ied_op_t op;
  logic [31:0] imm_s;
  logic [31:0] imm_z;
  logic [31:0] imm_h;
  logic [63:0] prod_ss;
  logic [63:0] prod_uu;
  logic [63:0] prod_su;
  logic [31:0] cmp_b;
  logic [31:0] alu;
  logic [31:0] ea;
  logic [31:0] ld_word;
  logic [31:0] ld_val;

  assign op = ied_pkg::ied_op_t'(i_op);
  assign imm_s = sext16(i_imm);
  assign imm_z = zext16(i_imm);
  assign imm_h = {i_imm, 16'h0000};
  assign ea = 32'(i_rs1 + imm_s);
  assign prod_ss = {{32{i_rs1[31]}}, i_rs1} *
                   {{32{i_rs2[31]}}, i_rs2};
  assign prod_uu = {32'h0, i_rs1} * {32'h0, i_rs2};
  assign prod_su = {{32{i_rs1[31]}}, i_rs1} * {32'h0, i_rs2};

  always_comb
  begin
    cmp_b = i_rs2;
    if (op >= ied_pkg::OP_CMPEQI)
    begin
      case (op)
        ied_pkg::OP_CMPGEUI, ied_pkg::OP_CMPGTUI, ied_pkg::OP_CMPLEUI,
        ied_pkg::OP_CMPLTUI:
          cmp_b = imm_z;
        default:
          cmp_b = imm_s;
      endcase
    end
  end

  always_comb
  begin
    alu = '0;
    case (op)
      ied_pkg::OP_AND: alu = i_rs1 & i_rs2;
      ied_pkg::OP_OR: alu = i_rs1 | i_rs2;
      ied_pkg::OP_XOR: alu = i_rs1 ^ i_rs2;
      ied_pkg::OP_NOR: alu = ~(i_rs1 | i_rs2);
      ied_pkg::OP_ANDI: alu = i_rs1 & imm_z;
      ied_pkg::OP_ORI: alu = i_rs1 | imm_z;
      ied_pkg::OP_XORI: alu = i_rs1 ^ imm_z;
      ied_pkg::OP_ANDHI: alu = i_rs1 & imm_h;
      ied_pkg::OP_ORHI: alu = i_rs1 | imm_h;
      ied_pkg::OP_XORHI: alu = i_rs1 ^ imm_h;
      ied_pkg::OP_ADD: alu = 32'(i_rs1 + i_rs2);
      ied_pkg::OP_SUB: alu = 32'(i_rs1 - i_rs2);
      ied_pkg::OP_MUL: alu = prod_uu[31:0];
      ied_pkg::OP_ADDI: alu = 32'(i_rs1 + imm_s);
      ied_pkg::OP_SUBI: alu = 32'(i_rs1 - imm_s);
      ied_pkg::OP_MULI: alu = 32'(i_rs1 * imm_s);
      ied_pkg::OP_MULXSS: alu = prod_ss[63:32];
      ied_pkg::OP_MULXUU: alu = prod_uu[63:32];
      ied_pkg::OP_MULXSU: alu = prod_su[63:32];
      ied_pkg::OP_MOV: alu = i_rs1;
      ied_pkg::OP_MOVI: alu = imm_s;
      ied_pkg::OP_MOVUI: alu = imm_z;
      ied_pkg::OP_MOVHI: alu = imm_h;
      ied_pkg::OP_CMPEQ, ied_pkg::OP_CMPEQI:
        alu = {31'h0, i_rs1 == cmp_b};
      ied_pkg::OP_CMPNE, ied_pkg::OP_CMPNEI:
        alu = {31'h0, i_rs1 != cmp_b};
      ied_pkg::OP_CMPGE, ied_pkg::OP_CMPGEI:
        alu = {31'h0, $signed(i_rs1) >= $signed(cmp_b)};
      ied_pkg::OP_CMPGEU, ied_pkg::OP_CMPGEUI:
        alu = {31'h0, i_rs1 >= cmp_b};
      ied_pkg::OP_CMPGT, ied_pkg::OP_CMPGTI:
        alu = {31'h0, $signed(i_rs1) > $signed(cmp_b)};
      ied_pkg::OP_CMPGTU, ied_pkg::OP_CMPGTUI:
        alu = {31'h0, i_rs1 > cmp_b};
      ied_pkg::OP_CMPLE, ied_pkg::OP_CMPLEI:
        alu = {31'h0, $signed(i_rs1) <= $signed(cmp_b)};
      ied_pkg::OP_CMPLEU, ied_pkg::OP_CMPLEUI:
        alu = {31'h0, i_rs1 <= cmp_b};
      ied_pkg::OP_CMPLT, ied_pkg::OP_CMPLTI:
        alu = {31'h0, $signed(i_rs1) < $signed(cmp_b)};
      ied_pkg::OP_CMPLTU, ied_pkg::OP_CMPLTUI:
        alu = {31'h0, i_rs1 < cmp_b};
      default: alu = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // Load data alignment and extension
  // ---------------------------------------------------------------
  assign ld_word = i_bus_rdata >> {st_reg.lane, 3'b000};

  always_comb
  begin
    case (st_reg.op)
      ied_pkg::OP_LDB: ld_val = {{24{ld_word[7]}}, ld_word[7:0]};
      ied_pkg::OP_LDBU: ld_val = {24'h0, ld_word[7:0]};
      ied_pkg::OP_LDH:
        ld_val = {{16{ld_word[15]}}, ld_word[15:0]};
      ied_pkg::OP_LDHU: ld_val = {16'h0, ld_word[15:0]};
      default: ld_val = i_bus_rdata;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  assign div_start = st_reg.state == ST_IDLE && i_valid &&
                     (op == ied_pkg::OP_DIV || op == ied_pkg::OP_DIVU);

  always_comb
  begin
    logic [3:0] be;
    logic [31:0] wd;
    st_next = st_reg;
    be = ied_pkg::BE_WORD;
    wd = i_rs2;
    st_next.wb_en = 1'b0;
    st_next.ready = 1'b0;
    case (st_reg.state)
      ST_IDLE:
      begin
        if (i_valid)
        begin
          st_next.op = op;
          st_next.wb_rd = i_rd;
          st_next.lane = ea[1:0];
          if (is_load(op) || is_store(op))
          begin
            case (mem_size(op))
              ied_pkg::SZ_BYTE: be = 4'(ied_pkg::BE_BYTE << ea[1:0]);
              ied_pkg::SZ_HALF:
                be = 4'(ied_pkg::BE_HALF << {ea[1], 1'b0});
              default: be = ied_pkg::BE_WORD;
            endcase
            wd = i_rs2 << {ea[1:0], 3'b000};
            st_next.state = ST_MEM;
            st_next.req = 1'b1;
            st_next.we = is_store(op);
            st_next.unc = i_io;
            st_next.addr = (mem_size(op) == ied_pkg::SZ_WORD) ?
                           {ea[31:2], 2'b00} : ea;
            st_next.be = be;
            st_next.wdata = wd;
          end
          else if (op == ied_pkg::OP_DIV || op == ied_pkg::OP_DIVU)
            st_next.state = ST_DIV;
          else
          begin
            st_next.ready = 1'b1;
            st_next.wb_en = (op != ied_pkg::OP_NONE);
            st_next.wb_data = alu;
          end
        end
      end
      ST_MEM:
      begin
        // Request held until acknowledged; never dropped
        if (i_bus_ack)
        begin
          st_next.req = 1'b0;
          st_next.state = ST_IDLE;
          st_next.ready = 1'b1;
          st_next.wb_en = !st_reg.we;
          st_next.wb_data = st_reg.we ? st_reg.wb_data : ld_val;
        end
      end
      ST_DIV:
      begin
        if (div_done)
        begin
          st_next.state = ST_IDLE;
          st_next.ready = 1'b1;
          st_next.wb_en = 1'b1;
          st_next.wb_data = div_quot;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  ied_divider u_div
  (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_start(div_start),
    .i_signed(op == ied_pkg::OP_DIV),
    .i_num(i_rs1),
    .i_den(i_rs2),
    .o_busy(div_busy),
    .o_done(div_done),
    .o_quot(div_quot)
  );

  assign o_ready = st_reg.ready;
  assign o_wb_en = st_reg.wb_en;
  assign o_wb_rd = st_reg.wb_rd;
  assign o_wb_data = st_reg.wb_data;
  assign o_bus_req = st_reg.req;
  assign o_bus_we = st_reg.we;
  assign o_bus_uncached = st_reg.unc;
  assign o_bus_addr = st_reg.addr;
  assign o_bus_be = st_reg.be;
  assign o_bus_wdata = st_reg.wdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  req_held_a: assert property (o_bus_req && !i_bus_ack |=> o_bus_req)
    else $error("bus request dropped before ack");
  ack_ready_a: assert property (o_bus_req && i_bus_ack |=> o_ready)
    else $error("no completion after ack");
  load_wb_a: assert property (o_bus_req && i_bus_ack && !o_bus_we |=> o_wb_en)
    else $error("load did not write back");
  store_nowb_a: assert property (o_bus_req && i_bus_ack && o_bus_we |=> !o_wb_en)
    else $error("store wrote a register");
  cmp_bool_a: assert property (o_wb_en && st_reg.op >= ied_pkg::OP_CMPEQ |-> o_wb_data[31:1] == 31'h0)
    else $error("compare result not boolean");
  movhi_low_a: assert property (st_reg.op == ied_pkg::OP_MOVHI && o_wb_en |-> o_wb_data[15:0] == 16'h0000)
    else $error("high move low half not zero");
  movui_high_a: assert property (st_reg.op == ied_pkg::OP_MOVUI && o_wb_en |-> o_wb_data[31:16] == 16'h0000)
    else $error("unsigned move high half not zero");
  byte_be_a: assert property (o_bus_req && st_reg.op == ied_pkg::OP_STB |-> $onehot(o_bus_be))
    else $error("byte store enables more than one lane");
  div_end_a: assert property (div_start |-> ##[33:34] o_ready)
    else $error("divide did not finish in time");
  div_busy_a: assert property (div_busy |-> st_reg.state == ST_DIV)
    else $error("divider busy outside divide state");
  unc_io_a: assert property (o_bus_req && !$past(o_bus_req) |-> o_bus_uncached == $past(i_io))
    else $error("uncached flag not taken from issue");

  load_c: cover property (o_bus_req && i_bus_ack && !o_bus_we);
  store_c: cover property (o_bus_req && i_bus_ack && o_bus_we && o_bus_uncached);
  div_c: cover property (div_done);
  alu_c: cover property (o_wb_en && st_reg.op == ied_pkg::OP_MULXSU);

endmodule : ied_execute

`default_nettype wire

// file: include/ied_pkg.sv
// Constants, operation codes and timing figures for the execute datapath
// Assumes decode hands over one operation code per issued instruction
package ied_pkg;

  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int IMM_W = 16;
  localparam int BE_W = 4;
  localparam int OP_W = 6;
  localparam int DIV_STEPS = 32;
  localparam int CLK_NS = 20;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hF;

  typedef enum logic [OP_W-1:0] {
    OP_NONE, OP_LDW, OP_STW, OP_LDB, OP_LDBU, OP_LDH, OP_LDHU, OP_STB,
    OP_STH, OP_AND, OP_OR, OP_XOR, OP_NOR, OP_ANDI, OP_ORI, OP_XORI,
    OP_ANDHI, OP_ORHI, OP_XORHI, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_DIVU,
    OP_ADDI, OP_SUBI, OP_MULI, OP_MULXSS, OP_MULXUU, OP_MULXSU, OP_MOV,
    OP_MOVI, OP_MOVUI, OP_MOVHI, OP_CMPEQ, OP_CMPNE, OP_CMPGE, OP_CMPGEU,
    OP_CMPGT, OP_CMPGTU, OP_CMPLE, OP_CMPLEU, OP_CMPLT, OP_CMPLTU,
    OP_CMPEQI, OP_CMPNEI, OP_CMPGEI, OP_CMPGEUI, OP_CMPGTI, OP_CMPGTUI,
    OP_CMPLEI, OP_CMPLEUI, OP_CMPLTI, OP_CMPLTUI
  } ied_op_t;

endpackage : ied_pkg

// file: core/ied_divider.sv
// Iterative restoring divider, one quotient bit per cycle
// Assumes start is only raised while busy is low
`timescale 1ns/1ps
`default_nettype none

module ied_divider
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_signed,
  input wire logic [31:0] i_num,
  input wire logic [31:0] i_den,
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_quot
);

  typedef struct packed {
    logic busy;
    logic done;
    logic neg;
    logic [5:0] cnt;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] den;
    logic [31:0] res;
  } ied_div_st_t;

  ied_div_st_t st_reg;
  ied_div_st_t st_next;

  always_comb
  begin
    logic [32:0] trial;
    logic [31:0] q;
    st_next = st_reg;
    trial = '0;
    q = '0;
    st_next.done = 1'b0;
    if (i_start)
    begin
      st_next.busy = 1'b1;
      st_next.cnt = 6'(ied_pkg::DIV_STEPS);
      st_next.rem = '0;
      st_next.neg = i_signed & (i_num[31] ^ i_den[31]);
      st_next.quo = (i_signed & i_num[31]) ? 32'(-i_num) : i_num;
      st_next.den = (i_signed & i_den[31]) ? 32'(-i_den) : i_den;
    end
    else if (st_reg.busy)
    begin
      trial = {st_reg.rem, st_reg.quo[31]} - {1'b0, st_reg.den};
      if (!trial[32])
      begin
        st_next.rem = trial[31:0];
        st_next.quo = {st_reg.quo[30:0], 1'b1};
      end
      else
      begin
        st_next.rem = {st_reg.rem[30:0], st_reg.quo[31]};
        st_next.quo = {st_reg.quo[30:0], 1'b0};
      end
      st_next.cnt = st_reg.cnt - 6'h01;
      if (st_reg.cnt == 6'h01)
      begin
        q = st_next.quo;
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.res = st_reg.neg ? 32'(-q) : q;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_busy = st_reg.busy;
  assign o_done = st_reg.done;
  assign o_quot = st_reg.res;

endmodule : ied_divider

`default_nettype wire

// file: bench/ied_mem_model.sv
// Byte-lane memory standing on the far side of the data bus
// Assumes one request at a time, held until the edge after its ack
`timescale 1ns/1ps
`default_nettype none

module ied_mem_model
(
  input wire logic i_core_clk,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_be,
  input wire logic [31:0] i_wdata,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [7:0] mem [0:63];
  logic [3:0] dly;
  logic [5:0] wa;

  // ----------------------------------------------------------------
  // Answer with a prompt or a late ack pulse
  // ----------------------------------------------------------------
  assign wa = {i_addr[5:2], 2'h0};
  initial
  begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
    dly = 4'h0;
    for (int i = 0; i < 64; i++) mem[i] = 8'h0;
  end
  always @(posedge i_core_clk)
  begin
    o_rdata <= ~o_rdata;
    if (o_ack)
      o_ack <= 1'b0;
    else if (i_req && dly != 4'h0)
      dly <= dly - 4'h1;
    else if (i_req)
    begin
      o_ack <= 1'b1;
      dly <= i_slow ? 4'($urandom_range(5, 1)) : 4'h0;
      o_rdata <= {mem[wa + 3], mem[wa + 2], mem[wa + 1], mem[wa]};
      for (int i = 0; i < 4; i++)
        if (i_we && i_be[i]) mem[wa + i] <= i_wdata[8 * i +: 8];
    end
  end
endmodule : ied_mem_model

`default_nettype wire

// file: bench/tb_integer_execute_datapath.sv
// Self-checking bench for the execute datapath with a reference model
// Assumes the memory model in ied_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module tb_integer_execute_datapath;
  logic i_core_clk = 1'b0;
  logic i_nrst, i_valid, i_io, i_bus_ack, slow;
  logic [5:0] i_op;
  logic [31:0] i_rs1, i_rs2, i_bus_rdata, o_wb_data, o_bus_addr, o_bus_wdata;
  logic [15:0] i_imm;
  logic [4:0] i_rd, o_wb_rd;
  logic o_ready, o_wb_en, o_bus_req, o_bus_we, o_bus_uncached;
  logic [3:0] o_bus_be;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] refm [0:63];
  logic [31:0] a, b, base, edg [0:3];
  logic [15:0] im;
  ied_pkg::ied_op_t ld [0:3];

  ied_execute dut (.i_core_clk, .i_nrst, .i_valid, .i_op, .i_io, .i_rs1,
    .i_rs2, .i_imm, .i_rd, .i_bus_ack, .i_bus_rdata, .o_ready, .o_wb_en,
    .o_wb_rd, .o_wb_data, .o_bus_req, .o_bus_we, .o_bus_uncached,
    .o_bus_addr, .o_bus_be, .o_bus_wdata);
  ied_mem_model mem (.i_core_clk, .i_slow(slow), .i_req(o_bus_req),
    .i_we(o_bus_we), .i_addr(o_bus_addr), .i_be(o_bus_be),
    .i_wdata(o_bus_wdata), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));

  always #10 i_core_clk = ~i_core_clk;

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // Reference model of register results
  // ----------------------------------------------------------------
  function automatic logic [31:0] ref_alu(ied_pkg::ied_op_t op,
    logic [31:0] x, logic [31:0] y, logic [15:0] i);
    logic [31:0] s, z, h;
    logic [63:0] pss, puu, psu;
    s = {{16{i[15]}}, i};
    z = {16'h0, i};
    h = {i, 16'h0};
    pss = {{32{x[31]}}, x} * {{32{y[31]}}, y};
    puu = {32'h0, x} * {32'h0, y};
    psu = {{32{x[31]}}, x} * {32'h0, y};
    case (op)
      ied_pkg::OP_AND: return x & y;
      ied_pkg::OP_OR: return x | y;
      ied_pkg::OP_XOR: return x ^ y;
      ied_pkg::OP_NOR: return ~(x | y);
      ied_pkg::OP_ANDI: return x & z;
      ied_pkg::OP_ORI: return x | z;
      ied_pkg::OP_XORI: return x ^ z;
      ied_pkg::OP_ANDHI: return x & h;
      ied_pkg::OP_ORHI: return x | h;
      ied_pkg::OP_XORHI: return x ^ h;
      ied_pkg::OP_ADD: return x + y;
      ied_pkg::OP_SUB: return x - y;
      ied_pkg::OP_MUL: return pss[31:0];
      ied_pkg::OP_DIV:
        return (x == 32'h80000000 && y == 32'hFFFFFFFF) ? $signed(x) :
               $signed(x) / $signed(y);
      ied_pkg::OP_DIVU: return x / y;
      ied_pkg::OP_ADDI: return x + s;
      ied_pkg::OP_SUBI: return x - s;
      ied_pkg::OP_MULI: return x * s;
      ied_pkg::OP_MULXSS: return pss[63:32];
      ied_pkg::OP_MULXUU: return puu[63:32];
      ied_pkg::OP_MULXSU: return psu[63:32];
      ied_pkg::OP_MOV: return x;
      ied_pkg::OP_MOVI: return s;
      ied_pkg::OP_MOVUI: return z;
      ied_pkg::OP_MOVHI: return h;
      ied_pkg::OP_CMPEQ: return {31'h0, x == y};
      ied_pkg::OP_CMPNE: return {31'h0, x != y};
      ied_pkg::OP_CMPGE: return {31'h0, $signed(x) >= $signed(y)};
      ied_pkg::OP_CMPGEU: return {31'h0, x >= y};
      ied_pkg::OP_CMPGT: return {31'h0, $signed(x) > $signed(y)};
      ied_pkg::OP_CMPGTU: return {31'h0, x > y};
      ied_pkg::OP_CMPLE: return {31'h0, $signed(x) <= $signed(y)};
      ied_pkg::OP_CMPLEU: return {31'h0, x <= y};
      ied_pkg::OP_CMPLT: return {31'h0, $signed(x) < $signed(y)};
      ied_pkg::OP_CMPLTU: return {31'h0, x < y};
      ied_pkg::OP_CMPEQI: return {31'h0, x == s};
      ied_pkg::OP_CMPNEI: return {31'h0, x != s};
      ied_pkg::OP_CMPGEI: return {31'h0, $signed(x) >= $signed(s)};
      ied_pkg::OP_CMPGEUI: return {31'h0, x >= z};
      ied_pkg::OP_CMPGTI: return {31'h0, $signed(x) > $signed(s)};
      ied_pkg::OP_CMPGTUI: return {31'h0, x > z};
      ied_pkg::OP_CMPLEI: return {31'h0, $signed(x) <= $signed(s)};
      ied_pkg::OP_CMPLEUI: return {31'h0, x <= z};
      ied_pkg::OP_CMPLTI: return {31'h0, $signed(x) < $signed(s)};
      default: return {31'h0, x < z};
    endcase
  endfunction : ref_alu

  // ----------------------------------------------------------------
  // One operation: issue, watch the bus, compare the result
  // ----------------------------------------------------------------
  task automatic run(input ied_pkg::ied_op_t op, input logic [31:0] x,
    input logic [31:0] y, input logic [15:0] i);
    int n;
    logic [31:0] ea, lw, ln, e, ws, bm;
    logic [3:0] be;
    logic [4:0] sh, rd;
    logic [5:0] wa;
    logic io, mop, we, word, half, seen;
    rd = 5'($urandom);
    io = 1'($urandom);
    ea = x + {{16{i[15]}}, i};
    sh = {ea[1:0], 3'h0};
    wa = {ea[5:2], 2'h0};
    mop = op >= ied_pkg::OP_LDW && op <= ied_pkg::OP_STH;
    we = op inside {ied_pkg::OP_STW, ied_pkg::OP_STB, ied_pkg::OP_STH};
    word = op inside {ied_pkg::OP_LDW, ied_pkg::OP_STW};
    half = op inside {ied_pkg::OP_LDH, ied_pkg::OP_LDHU, ied_pkg::OP_STH};
    be = word ? ied_pkg::BE_WORD : (half ? ied_pkg::BE_HALF : ied_pkg::BE_BYTE);
    be = be << ea[1:0];
    for (int k = 0; k < 4; k++) bm[8 * k +: 8] = {8{be[k]}};
    ws = y << sh;
    lw = {refm[wa + 3], refm[wa + 2], refm[wa + 1], refm[wa]};
    ln = lw >> sh;
    case (op)
      ied_pkg::OP_LDW: e = lw;
      ied_pkg::OP_LDB: e = {{24{ln[7]}}, ln[7:0]};
      ied_pkg::OP_LDBU: e = {24'h0, ln[7:0]};
      ied_pkg::OP_LDH: e = {{16{ln[15]}}, ln[15:0]};
      ied_pkg::OP_LDHU: e = {16'h0, ln[15:0]};
      default: e = ref_alu(op, x, y, i);
    endcase
    @(posedge i_core_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_io <= io;
    i_rs1 <= x;
    i_rs2 <= y;
    i_imm <= i;
    i_rd <= rd;
    @(posedge i_core_clk);
    i_valid <= 1'b0;
    n = 0;
    seen = 1'b0;
    do
    begin
      @(negedge i_core_clk);
      n++;
      if (o_bus_req === 1'b1)
      begin
        seen = 1'b1;
        chk(o_bus_addr, word ? {ea[31:2], 2'h0} : ea);
        chk({o_bus_we, o_bus_uncached, o_bus_be}, {we, io, be});
        if (we) chk(o_bus_wdata & bm, ws & bm);
      end
    end
    while (o_ready !== 1'b1 && n <= 100);
    if (n > 100)
    begin
      failures++;
      end_sim();
    end
    else
    begin
      chk({seen, o_wb_en, o_wb_rd}, {mop, !we, rd});
      if (!we) chk(o_wb_data, e);
      for (int k = 0; k < 4; k++)
        if (we && be[k]) refm[wa + k] = ws[8 * k +: 8];
    end
  endtask : run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_nrst = 1'b0;
    i_valid = 1'b0;
    i_op = 6'h0;
    i_io = 1'b0;
    i_rs1 = 32'h0;
    i_rs2 = 32'h0;
    i_imm = 16'h0;
    i_rd = 5'h0;
    slow = 1'b0;
    edg = '{32'h0, 32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF};
    ld = '{ied_pkg::OP_LDB, ied_pkg::OP_LDBU, ied_pkg::OP_LDH, ied_pkg::OP_LDHU};
    for (int k = 0; k < 64; k++) refm[k] = 8'h0;
    a = $urandom(24803);
    repeat (10) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    for (int r = 0; r < 8; r++)
      for (int k = ied_pkg::OP_AND; k <= ied_pkg::OP_CMPLTUI; k++)
      begin
        a = $urandom;
        b = (r % 3 == 0) ? a : $urandom;
        im = 16'($urandom);
        if (r == 1) a = {{16{im[15]}}, im};
        if (r >= 5) a = edg[$urandom % 4];
        if (r >= 5) b = edg[$urandom % 4];
        if (r >= 6) im = (r == 6) ? 16'h8000 : 16'hFFFF;
        if (k == ied_pkg::OP_DIV || k == ied_pkg::OP_DIVU)
          b = (b >> ($urandom % 31)) | 32'h1;
        run(ied_pkg::ied_op_t'(k), a, b, im);
      end
    base = 32'h00001040;
    for (int r = 0; r < 8; r++)
    begin
      slow <= r[0];
      im = 16'($urandom & 32'h3C) - 16'h0040;
      run(ied_pkg::OP_STW, base, $urandom, im);
      for (int l = 0; l < 4; l++)
        for (int j = 0; j < 4; j++)
          if (j < 2 || l % 2 == 0) run(ld[j], base, 32'h0, im + 16'(l));
      run(ied_pkg::OP_LDW, base, 32'h0, im);
      run(ied_pkg::OP_STB, base, $urandom, im + 16'($urandom % 4));
      run(ied_pkg::OP_STH, base, $urandom, im + 16'(2 * ($urandom % 2)));
      run(ied_pkg::OP_LDW, base, 32'h0, im);
    end
    end_sim();
  end
endmodule : tb_integer_execute_datapath

`default_nettype wire
